// ### tb_top.sv
// self-checking bench for the baud, auto-baud, wake and break block
`timescale 1ns/100ps
module tb_top;
    import ubrk_pkg::*;
    logic clk_i = 0, srst_i = 1, avs_read = 0, avs_write = 0, rx, tx_o, st, wk, hold;
    logic [4:0] avs_address = '0;
    logic [31:0] avs_writedata = '0, avs_readdata, q;
    logic avs_waitrequest;
    logic [7:0] txd, exp_q[$];
    int err_count = 0, check_count = 0, cyc = 0, n;
    ubrk_remote rem (.clk_i(clk_i), .rx_o(rx));
    ubrk_core uut (.clk_i(clk_i), .srst_i(srst_i), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_i(rx),
        .tx_o(tx_o), .lin_sync_start_i(1'b0), .tx_shift_busy_i(1'b0), .baud_tick_o(),
        .rx_hold_o(hold), .tx_start_o(st), .tx_data_o(txd), .overflow_irq_o(),
        .wake_irq_o(wk));
    // 200 MHz clock
    initial forever #2.5 clk_i = ~clk_i;
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one avalon cycle held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk_i);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        @(posedge clk_i iff avs_waitrequest === 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // watcher: each handed-over character is matched to the oldest note
    always @(posedge clk_i) begin
        if (st === 1'b1) begin
            if (exp_q.size() == 0) check("tx_start", 0, 1);
            else check("tx_data", exp_q.pop_front(), txd);
        end
    end
    // hang limit
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_count++;
            tally_and_finish();
        end
    end
    initial begin
        void'($urandom(78));
        repeat (2) @(posedge clk_i);
        srst_i <= 1'b0;
        bus(0, ADDR_CTRL0, 0); check("ctrl0", 0, q);
        bus(0, ADDR_FLAGS, 0); check("flags", 32'h0000_0018, q);
        bus(0, 5'h1c, 0); check("unmapped", 0, q);
        n = $urandom % 256;
        bus(1, ADDR_DIV_LO, n); bus(0, ADDR_DIV_LO, 0); check("div_lo", n, q);
        $display("registers done");
        // fast range, sync at 128 clocks a bit: 1024 / 32 counts
        bus(1, ADDR_CTRL0, 32'h0000_00c0);
        rem.send(8'h55, 128);
        bus(0, ADDR_DIV_LO, 0); check("abd_div", 32, q);
        bus(0, ADDR_CTRL0, 0); check("abd_en", 32'h0000_0080, q);
        bus(0, ADDR_FLAGS, 0); check("abd_done", 1, q[F_ABD_DONE]);
        $display("autobaud done");
        // abort: normal range, one low pulse starts the count, then software aborts
        bus(1, ADDR_CTRL0, 32'h0000_0040);
        rem.brk(64);
        check("rx_hold", 1, hold);
        bus(1, ADDR_CTRL0, 0);
        bus(1, ADDR_FLAGS, 0);
        bus(0, ADDR_FLAGS, 0);
        check("abort", 32'h0000_0018, q);
        $display("abort done");
        // fixed break at divisor 32, fast: 13 periods of 132 clocks low
        bus(1, ADDR_CTRL0, 32'h0000_00a0);
        bus(1, ADDR_CTRL1, 1);
        exp_q.push_back(8'ha5);
        bus(1, ADDR_TXBUF, 32'h0000_00a5);
        while (tx_o !== 1'b0) @(posedge clk_i);
        n = 0;
        while (tx_o === 1'b0) begin
            @(posedge clk_i);
            n++;
        end
        check("break_low", 13 * 132, n);
        repeat (300) @(posedge clk_i);
        bus(0, ADDR_CTRL1, 0); check("send_break", 0, q[C1_SEND_BREAK]);
        bus(1, ADDR_CTRL1, 2); repeat (3) @(posedge clk_i);
        check("override", 0, tx_o);
        bus(1, ADDR_CTRL1, 0); repeat (3) @(posedge clk_i);
        check("release", 1, tx_o);
        $display("break done");
        // wake: enables set, eleven-bit zero character
        bus(1, ADDR_FLAGS, 0);
        bus(1, ADDR_IRQEN, 32'h0000_001a);
        bus(0, ADDR_FLAGS, 0);
        check("rx_idle", 1, q[F_RX_IDLE]);
        bus(1, ADDR_CTRL1, 32'h0000_0010);
        rem.brk(11 * 132);
        check("wake_irq", 1, wk);
        repeat (10) @(posedge clk_i);
        bus(0, ADDR_CTRL1, 0); check("wake_clr", 0, q[C1_WAKE]);
        bus(0, ADDR_FLAGS, 0); check("wake_flag", 1, q[F_WAKE]);
        bus(1, ADDR_FLAGS, 0); bus(0, ADDR_FLAGS, 0);
        check("flags_clr", 0, q[2:0]);
        $display("wake done");
        tally_and_finish();
    end
endmodule

// ### ubrk_core.sv
// baud generator, auto-baud measurement, wake-on-break and break transmit
//
// The implementer's own choices: the Avalon-MM slave port and the register addresses.
`timescale 1ns/100ps
// How it works
// R1 - baud equals sysclk over 4 or 16 times divisor plus one
// R2 - auto-baud in 8-bit async and LIN; LIN starts it per packet
// R3 - DALI mode ignores auto-baud enable; software sets 1200 baud
// R4 - during auto-baud receive edges time the counter; sync is 55h
// R5 - first falling edge starts counting; receiver held idle meanwhile (held here only while autobaud enable is set, not for LIN starts)
// R6 - fifth falling edge loads divisor, clears enable, sets done flag
// R7 - receive idle falls at first falling edge, rises at fifth rising
// R8 - internal 16-bit counter; visible divisor kept until success
// R9 - measuring counter runs at one eighth of base divisor clock
// R10 - with wake and auto-baud set, measure character after the break
// R11 - counter overflow sets overflow flag; finish without divisor update
// R12 - software clears done and overflow; overflow irq needs four enables
// R13 - software aborts by clearing enable then overflow flag
// R14 - wake plus uart irq enable disables reception, watches for activity
// R15 - wake flag set at wake event, cleared only by software
// R16 - wake enable cleared by hardware when line returns idle
// R17 - sender opens wake with zero character of eleven bit times
// R18 - nonzero character: start-to-first-rise low time is the wake event
// R19 - software checks receive idle before setting wake enable
// R20 - fixed break is start, twelve zero bits, stop
// R21 - break override forces transmit line to non-idle level
// R22 - send-break plus tx write: break then character; send_break self clears
// R23 - divisor write resets the baud counter at once
// R24 - speed select gives 4 or 16 baud clocks per bit
// R25 - baud counter reloads at divisor and ticks once per reload
// R26 - receive input passes a two-stage synchronizer first
module ubrk_core
    import ubrk_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // avalon-mm slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // serial line
    input wire logic rx_i,
    output logic tx_o,
    // hooks to the shifter core
    input wire logic lin_sync_start_i,
    input wire logic tx_shift_busy_i,
    output logic baud_tick_o,
    output logic rx_hold_o,
    output logic tx_start_o,
    output logic [7:0] tx_data_o,
    output logic overflow_irq_o,
    output logic wake_irq_o
);
    logic [7:0] ctrl0;
    logic [7:0] ctrl1;
    logic [15:0] divisor;
    logic [4:0] irq_en;
    logic abd_done;
    logic abd_ovf;
    logic wake_flag;
    logic rx_idle;
    logic rx_s1, rx_s2, rx_d;
    logic rx_fall, rx_rise;
    logic [15:0] baud_cnt;
    logic [15:0] meas_cnt;
    logic meas_ovf;
    logic [2:0] fall_cnt;
    logic [2:0] rise_cnt;
    ubrk_abd_t abd_state;
    ubrk_tx_t tx_state;
    logic [3:0] brk_bits;
    logic brk_pend;
    logic base_tick;
    logic ack;
    logic wr_div, wr_tx;
    logic abd_run, abd_finish, abd_clr_en, abd_start;
    logic wake_active, wake_event, wake_end;
    logic send_break_clr;
    logic [3:0] mode;

    assign mode = ctrl0[3:0];

    // decode helper so every write path uses the same address test
    function automatic logic hit(input logic [4:0] a, input logic [4:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    // one-wait-state slave: waitrequest drops one cycle after request
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ack <= 1'b0;
        end else begin
            ack <= (avs_read || avs_write) && !ack;
        end
    end
    assign avs_waitrequest = !ack;
    assign wr_div = avs_write && ack && (hit(avs_address, ADDR_DIV_LO)
        || hit(avs_address, ADDR_DIV_HI));
    assign wr_tx = avs_write && ack && hit(avs_address, ADDR_TXBUF);

    // read data registered; unmapped addresses read zero
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            avs_readdata <= 32'h0000_0000;
        end else if (avs_read && !ack) begin
            if (hit(avs_address, ADDR_CTRL0)) begin
                avs_readdata <= {24'h00_0000, ctrl0};
            end else if (hit(avs_address, ADDR_CTRL1)) begin
                avs_readdata <= {24'h00_0000, ctrl1 & 8'h13};
            end else if (hit(avs_address, ADDR_DIV_LO)) begin
                avs_readdata <= {24'h00_0000, divisor[7:0]};
            end else if (hit(avs_address, ADDR_DIV_HI)) begin
                avs_readdata <= {24'h00_0000, divisor[15:8]};
            end else if (hit(avs_address, ADDR_FLAGS)) begin
                avs_readdata <= {27'h000_0000, (tx_state == UBRK_TX_IDLE) && !brk_pend,
                    rx_idle, wake_flag, abd_ovf, abd_done};
            end else if (hit(avs_address, ADDR_IRQEN)) begin
                avs_readdata <= {27'h000_0000, irq_en};
            end else begin
                avs_readdata <= 32'h0000_0000;
            end
        end
    end

    // receive synchronizer, then edge detection on the second stage [R26]
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
            rx_d <= 1'b1;
        end else begin
            rx_s1 <= rx_i;
            rx_s2 <= rx_s1;
            rx_d <= rx_s2;
        end
    end
    assign rx_fall = rx_d && !rx_s2;
    assign rx_rise = !rx_d && rx_s2;

    // prescaler: base clock or one-eighth rate while measuring [R9] [R24]
    ubrk_prescale u_pre (
        .clk_i(clk_i),
        .srst_i(srst_i),
        .restart_i(wr_div || abd_start),
        .fast_i(ctrl0[C0_SPEED]),
        .abd_i(abd_run),
        .tick_o(base_tick)
    );

    // baud counter reloads at the divisor; a divisor write clears it [R1] [R23] [R25]
    always_ff @(posedge clk_i) begin
        if (srst_i || wr_div || abd_run) begin
            baud_cnt <= 16'h0000;
            baud_tick_o <= 1'b0;
        end else if (base_tick && baud_cnt >= divisor) begin
            baud_cnt <= 16'h0000;
            baud_tick_o <= 1'b1;
        end else begin
            baud_cnt <= baud_cnt + (base_tick ? 16'h0001 : 16'h0000);
            baud_tick_o <= 1'b0;
        end
    end

    // wake watching: needs wake enable and uart irq enable [R14]
    assign wake_active = ctrl1[C1_WAKE] && irq_en[E_UART];
    assign wake_event = wake_active && rx_fall; // [R15] [R18]
    assign wake_end = ctrl1[C1_WAKE] && rx_rise; // [R16]

    // auto-baud allowed in 8-bit async modes, never DALI; LIN starts itself [R2] [R3]
    function automatic logic abd_mode_ok(input logic [3:0] m);
        abd_mode_ok = (m == MODE_ASYNC8) || (m == MODE_PAR_ODD) || (m == MODE_PAR_EVEN);
    endfunction

    // auto-baud sequencer; wake enable postpones the start of counting until after the break [R10]
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            abd_state <= UBRK_ABD_IDLE;
        end else begin
            case (abd_state)
                UBRK_ABD_IDLE: begin
                    if ((ctrl0[C0_AUTOBAUD_ENABLE] && abd_mode_ok(mode)) || ((mode == MODE_LIN_S
                        || mode == MODE_LIN_MS) && lin_sync_start_i)) begin // [R2] [R3]
                        abd_state <= UBRK_ABD_ARM;
                    end
                end
                UBRK_ABD_ARM: begin
                    if (abd_clr_en) begin
                        abd_state <= UBRK_ABD_IDLE;
                    end else if (rx_fall && !ctrl1[C1_WAKE]) begin
                        abd_state <= UBRK_ABD_RUN; // [R5] [R10]
                    end
                end
                UBRK_ABD_RUN: begin
                    if (abd_finish || abd_clr_en) begin
                        abd_state <= UBRK_ABD_IDLE; // [R6] [R13]
                    end
                end
                default: abd_state <= UBRK_ABD_IDLE;
            endcase
        end
    end
    assign abd_run = (abd_state == UBRK_ABD_RUN);
    assign abd_finish = abd_run && rx_fall && fall_cnt == SYNC_EDGES - 3'h1;
    // outside the LIN modes, software dropping the enable aborts an armed or running measurement
    assign abd_clr_en = !ctrl0[C0_AUTOBAUD_ENABLE] && !(mode == MODE_LIN_S || mode == MODE_LIN_MS);
    // first fall while armed; restarting the prescaler here fixes the tick phase
    assign abd_start = (abd_state == UBRK_ABD_ARM) && rx_fall && !ctrl1[C1_WAKE] && !abd_clr_en;

    // internal measuring counter and edge counters [R4] [R8] [R11]
    always_ff @(posedge clk_i) begin
        if (srst_i || abd_state == UBRK_ABD_IDLE) begin
            meas_cnt <= 16'h0000;
            meas_ovf <= 1'b0;
            fall_cnt <= 3'h0;
        end else if (abd_state == UBRK_ABD_ARM) begin
            fall_cnt <= abd_start ? 3'h1 : 3'h0;
            // the interval in progress counts, so the result rounds up to whole ticks
            meas_cnt <= abd_start ? 16'h0001 : 16'h0000;
        end else begin
            if (base_tick) begin
                {meas_ovf, meas_cnt} <= {meas_ovf, 16'h0000} | 17'({1'b0, meas_cnt} + 17'h1);
            end
            if (rx_fall) begin
                fall_cnt <= fall_cnt + 3'h1;
            end
        end
    end

    // receive idle: low from first fall to fifth rise of the sync char [R7]
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_idle <= 1'b1;
            rise_cnt <= 3'h0;
        end else if (abd_start) begin
            rx_idle <= 1'b0;
            rise_cnt <= 3'h0;
        end else if (abd_run && abd_clr_en) begin
            rx_idle <= 1'b1; // aborted sync must not leave the line marked busy [R13]
        end else if (!rx_idle && rx_rise) begin
            rise_cnt <= rise_cnt + 3'h1;
            if (rise_cnt == SYNC_EDGES - 3'h1) begin
                rx_idle <= 1'b1;
            end
        end
    end

    // receiver held idle during measurement while autobaud enable is set, and during wake watching [R5] [R14]
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            rx_hold_o <= 1'b0;
        end else begin
            rx_hold_o <= (abd_state != UBRK_ABD_IDLE && ctrl0[C0_AUTOBAUD_ENABLE]) || wake_active;
        end
    end

    // control_reg_0: autobaud_enable cleared by hardware at completion [R6] [R11]
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl0 <= RST_CTRL;
        end else if (avs_write && ack && hit(avs_address, ADDR_CTRL0)) begin
            ctrl0 <= avs_writedata[7:0];
        end else if (abd_finish) begin
            ctrl0[C0_AUTOBAUD_ENABLE] <= 1'b0;
        end
    end

    // control_reg_1: wake and send-break self clear [R16] [R22]
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            ctrl1 <= RST_CTRL;
        end else if (avs_write && ack && hit(avs_address, ADDR_CTRL1)) begin
            ctrl1 <= avs_writedata[7:0] & 8'h9b;
        end else begin
            if (wake_end) begin
                ctrl1[C1_WAKE] <= 1'b0;
            end
            if (send_break_clr) begin
                ctrl1[C1_SEND_BREAK] <= 1'b0;
            end
        end
    end

    // visible divisor: software write or successful measurement only [R6] [R8] [R11]
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            divisor <= RST_DIV;
        end else if (wr_div && hit(avs_address, ADDR_DIV_LO)) begin
            divisor[7:0] <= avs_writedata[7:0];
        end else if (wr_div) begin
            divisor[15:8] <= avs_writedata[7:0];
        end else if (abd_finish && !meas_ovf) begin
            divisor <= meas_cnt;
        end
    end

    // sticky flags: hardware set wins over a software clear in the same cycle [R12] [R15]
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            abd_done <= 1'b0;
            abd_ovf <= 1'b0;
            wake_flag <= 1'b0;
        end else begin
            if (avs_write && ack && hit(avs_address, ADDR_FLAGS)) begin
                abd_done <= avs_writedata[F_ABD_DONE] & abd_done;
                abd_ovf <= avs_writedata[F_ABD_OVF] & abd_ovf;
                wake_flag <= avs_writedata[F_WAKE] & wake_flag;
            end
            if (abd_finish) begin
                abd_done <= 1'b1; // [R6]
            end
            if (abd_run && meas_ovf) begin
                abd_ovf <= 1'b1; // [R11]
            end
            if (wake_event) begin
                wake_flag <= 1'b1;
            end
        end
    end

    // interrupt enables and gated interrupt outputs [R12]
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            irq_en <= 5'h00;
            overflow_irq_o <= 1'b0;
            wake_irq_o <= 1'b0;
        end else begin
            if (avs_write && ack && hit(avs_address, ADDR_IRQEN)) begin
                irq_en <= avs_writedata[4:0];
            end
            overflow_irq_o <= abd_ovf && (&{irq_en[E_OVF], irq_en[E_ERR],
                irq_en[E_PERIPH], irq_en[E_GLOBAL]});
            wake_irq_o <= wake_flag && (&{irq_en[E_UART], irq_en[E_PERIPH],
                irq_en[E_GLOBAL]});
        end
    end

    // break transmitter: 13 low bits then stop bit, then hand over the char [R20] [R22]
    // one baud tick is one bit in either range; the start waits for a tick so the
    // first low bit is a full period
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_state <= UBRK_TX_IDLE;
            brk_bits <= 4'h0;
            brk_pend <= 1'b0;
            tx_start_o <= 1'b0;
            tx_data_o <= 8'h00;
        end else begin
            tx_start_o <= 1'b0;
            case (tx_state)
                UBRK_TX_IDLE: begin
                    if (brk_pend && baud_tick_o) begin
                        brk_pend <= 1'b0;
                        brk_bits <= 4'h0;
                        tx_state <= UBRK_TX_LOW;
                    end else if (wr_tx && ctrl0[C0_TRANSMIT_ENABLE] && !brk_pend) begin
                        tx_data_o <= avs_writedata[7:0];
                        if (ctrl1[C1_SEND_BREAK]) begin
                            brk_pend <= 1'b1;
                        end else begin
                            tx_start_o <= 1'b1;
                        end
                    end
                end
                UBRK_TX_LOW: begin
                    if (baud_tick_o) begin
                        brk_bits <= brk_bits + 4'h1;
                        if (brk_bits == BRK_BITS - 4'h1) begin
                            tx_state <= UBRK_TX_STOP;
                        end
                    end
                end
                UBRK_TX_STOP: begin
                    if (baud_tick_o) begin
                        tx_state <= UBRK_TX_DATA;
                    end
                end
                UBRK_TX_DATA: begin
                    if (!tx_shift_busy_i) begin
                        tx_start_o <= 1'b1;
                        tx_state <= UBRK_TX_IDLE;
                    end
                end
                default: tx_state <= UBRK_TX_IDLE;
            endcase
        end
    end
    assign send_break_clr = (tx_state == UBRK_TX_STOP) && baud_tick_o; // [R22]

    // tx line: override or break low forces non-idle level [R21]
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            tx_o <= 1'b1;
        end else begin
            tx_o <= !(ctrl1[C1_BREAK_OVERRIDE] || tx_state == UBRK_TX_LOW);
        end
    end

    a_div_keep_ovf: assert property (@(posedge clk_i) disable iff (srst_i)
        (abd_finish && meas_ovf && !wr_div) |=> $stable(divisor))
        else $error("divisor changed after overflowed measurement"); // [R11]
    a_abd_load_div: assert property (@(posedge clk_i) disable iff (srst_i)
        (abd_finish && !meas_ovf && !wr_div) |=> divisor == $past(meas_cnt))
        else $error("measured period not loaded"); // [R6]
    a_abd_done_clr: assert property (@(posedge clk_i) disable iff (srst_i)
        abd_finish |=> abd_done && !ctrl0[C0_AUTOBAUD_ENABLE] || $past(avs_write))
        else $error("done flag or enable wrong after sync"); // [R6]
    a_wake_flag_set: assert property (@(posedge clk_i) disable iff (srst_i)
        wake_event |=> wake_flag) else $error("wake flag missed event"); // [R15]
    a_wake_clear: assert property (@(posedge clk_i) disable iff (srst_i)
        (wake_end && !(avs_write && ack)) |=> !ctrl1[C1_WAKE])
        else $error("wake enable not cleared at break end"); // [R16]
    a_brk_override: assert property (@(posedge clk_i) disable iff (srst_i)
        ctrl1[C1_BREAK_OVERRIDE] |=> !tx_o) else $error("override did not force tx low"); // [R21]
    a_div_restart: assert property (@(posedge clk_i) disable iff (srst_i)
        wr_div |=> baud_cnt == 16'h0000 && !baud_tick_o)
        else $error("divisor write did not reset counter"); // [R23]
    a_ovf_irq_gate: assert property (@(posedge clk_i) disable iff (srst_i)
        overflow_irq_o |-> $past(abd_ovf && irq_en[E_ERR] && irq_en[E_GLOBAL]))
        else $error("overflow irq without enables"); // [R12]
    a_rx_idle_low: assert property (@(posedge clk_i) disable iff (srst_i)
        abd_run |-> !rx_idle || $past(rx_rise)) else $error("rx idle high in sync"); // [R7]
    a_rx_hold: assert property (@(posedge clk_i) disable iff (srst_i)
        (abd_run && ctrl0[C0_AUTOBAUD_ENABLE]) |=> rx_hold_o) else $error("receiver not held"); // [R5]

    c_abd_ok: cover property (@(posedge clk_i) abd_finish && !meas_ovf);
    c_abd_ovf: cover property (@(posedge clk_i) abd_finish && meas_ovf);
    c_wake: cover property (@(posedge clk_i) wake_event);
    c_break: cover property (@(posedge clk_i) send_break_clr);
endmodule

// ### ubrk_pkg.sv
// package with register map, fields and constants for the baud, auto-baud, wake and break block
package ubrk_pkg;
    // register byte offsets (one aligned 32-bit word each)
    localparam logic [4:0] ADDR_CTRL0 = 5'h00;
    localparam logic [4:0] ADDR_CTRL1 = 5'h04;
    localparam logic [4:0] ADDR_DIV_LO = 5'h08;
    localparam logic [4:0] ADDR_DIV_HI = 5'h0c;
    localparam logic [4:0] ADDR_FLAGS = 5'h10;
    localparam logic [4:0] ADDR_IRQEN = 5'h14;
    localparam logic [4:0] ADDR_TXBUF = 5'h18;
    // control_reg_0 fields
    localparam int C0_SPEED = 7;
    localparam int C0_AUTOBAUD_ENABLE = 6;
    localparam int C0_TRANSMIT_ENABLE = 5;
    localparam int C0_RXEN = 4;
    // control_reg_1 fields
    localparam int C1_WAKE = 4;
    localparam int C1_BREAK_OVERRIDE = 1;
    localparam int C1_SEND_BREAK = 0;
    // flag register fields
    localparam int F_ABD_DONE = 0;
    localparam int F_ABD_OVF = 1;
    localparam int F_WAKE = 2;
    localparam int F_RX_IDLE = 3;
    localparam int F_TX_IDLE = 4;
    // irq enable register fields
    localparam int E_OVF = 0;
    localparam int E_UART = 1;
    localparam int E_ERR = 2;
    localparam int E_PERIPH = 3;
    localparam int E_GLOBAL = 4;
    // mode field encodings
    localparam logic [3:0] MODE_ASYNC8 = 4'h0;
    localparam logic [3:0] MODE_PAR_ODD = 4'h2;
    localparam logic [3:0] MODE_PAR_EVEN = 4'h3;
    localparam logic [3:0] MODE_LIN_S = 4'hb;
    localparam logic [3:0] MODE_LIN_MS = 4'hc;
    localparam logic [2:0] MODE_DALI_TOP = 3'h4;
    // reset values
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [15:0] RST_DIV = 16'h0000;
    // prescale: base clock is sysclk/4 or sysclk/16, auto-baud clock eight times slower
    localparam int PRE_FAST = 4;
    localparam int PRE_NORM = 16;
    localparam int ABD_DIV = 8;
    localparam int PRE_W = 7;
    localparam logic [PRE_W-1:0] PRE_FAST_LAST = PRE_W'(PRE_FAST - 1);
    localparam logic [PRE_W-1:0] PRE_NORM_LAST = PRE_W'(PRE_NORM - 1);
    localparam logic [PRE_W-1:0] ABD_FAST_LAST = PRE_W'(PRE_FAST * ABD_DIV - 1);
    localparam logic [PRE_W-1:0] ABD_NORM_LAST = PRE_W'(PRE_NORM * ABD_DIV - 1);
    // fixed break: start + 12 zeros + stop, in bit periods
    localparam int BRK_ZEROS = 12;
    localparam logic [3:0] BRK_BITS = 4'(BRK_ZEROS + 1);
    // auto-baud falling edges in a 55h sync character
    localparam logic [2:0] SYNC_EDGES = 3'h5;
    // auto-baud states
    typedef enum logic [1:0] {
        UBRK_ABD_IDLE = 2'b00,
        UBRK_ABD_ARM = 2'b01,
        UBRK_ABD_RUN = 2'b11
    } ubrk_abd_t;
    // transmit break states
    typedef enum logic [1:0] {
        UBRK_TX_IDLE = 2'b00,
        UBRK_TX_LOW = 2'b01,
        UBRK_TX_STOP = 2'b11,
        UBRK_TX_DATA = 2'b10
    } ubrk_tx_t;
endpackage

// ### ubrk_prescale.sv
// prescaler that turns the system clock into base or auto-baud tick pulses
`timescale 1ns/100ps
module ubrk_prescale
    import ubrk_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // control
    input wire logic restart_i,
    input wire logic fast_i,
    input wire logic abd_i,
    // tick out
    output logic tick_o
);
    logic [PRE_W-1:0] cnt;
    logic [PRE_W-1:0] last;

    // terminal count from speed and measure mode [R9] [R24]
    always_comb begin
        if (abd_i) begin
            last = fast_i ? ABD_FAST_LAST : ABD_NORM_LAST;
        end else begin
            last = fast_i ? PRE_FAST_LAST : PRE_NORM_LAST;
        end
    end

    // free running divider, restarted on divisor writes and at measurement start
    always_ff @(posedge clk_i) begin
        if (srst_i || restart_i) begin
            cnt <= '0;
            tick_o <= 1'b0;
        end else if (cnt >= last) begin
            cnt <= '0;
            tick_o <= 1'b1;
        end else begin
            cnt <= cnt + PRE_W'(1);
            tick_o <= 1'b0;
        end
    end

    a_tick_spacing: assert property (@(posedge clk_i) disable iff (srst_i)
        tick_o |=> !tick_o) else $error("prescale tick not a single pulse"); // [R9]
endmodule

// ### ubrk_remote.sv
// remote serial sender that drives the receive line of the block
`timescale 1ns/100ps
module ubrk_remote (
    // clock
    input wire logic clk_i,
    // line
    output logic rx_o
);
    initial rx_o = 1'b1;
    // one frame, start low, lsb first, stop high; idles high between frames
    task automatic send(input logic [7:0] b, input int per);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk_i);
            rx_o <= f[i];
            repeat (per - 1) @(posedge clk_i);
        end
    endtask
    // all-zero wake character held for n clocks, then back to idle
    task automatic brk(input int n);
        @(posedge clk_i);
        rx_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        rx_o <= 1'b1;
    endtask
endmodule
